// ==== hw/watchdog_timer_control.sv ====
// Watchdog timer control: APB register file, unlock window, mode logic
//
// Summary of operation
// - Expiry in interrupt configuration sets time-out flag
// - Entering watchdog handler clears time-out flag
// - Writing one clears flag; zero leaves it
// - Interrupt needs global enable, enable, flag
// - Mode from fuse, reset enable, interrupt enable
// - Interrupt enable alone: interrupt at each expiry
// - Combined mode: first expiry only sets flag
// - Combined mode handler entry clears enable, flag
// - Combined mode: unserviced flag, next expiry resets
// - Reset-enable clear, period change need unlock
// - Unlock bit self-clears four cycles later
// - Reset-cause flag forces reset enable to one
// - Period bits at 5 and 2..0
// - Period code n: 2048 shl n cycles; codes above 9 act as 9
// - Watchdog stays enabled after watchdog reset
// - Fuse forces reset enable one, interrupt zero
// - Counts oscillator cycles; restart returns to zero
// - Watchdog reset sets cause; zero-write clears it
`timescale 1ns/1ps
module watchdog_timer_control #(
   parameter int unsigned base_cycles = wd_pkg::PERIOD_BASE
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        wd_osc_clk,
   input  wire logic        wd_always_on_fuse,
   input  wire logic        global_irq_enable,
   input  wire logic        wd_irq_enter,
   input  wire logic        wd_restart,
   output logic             wd_irq_req,
   output logic             sys_reset_req
);

   // Bus slave state
   logic        pready_reg;
   logic        pslverr_reg;
   logic [31:0] prdata_reg;

   // Fuse pin synchroniser
   logic        fuse_s1_reg;
   logic        fuse_s2_reg;

   // Control and status state
   logic        flag_reg;
   logic        ie_reg;
   logic        ce_reg;
   logic        wde_reg;
   logic        cause_reg;
   logic [3:0]  period_reg;
   logic [wd_pkg::UNLOCK_CNT_W-1:0] ce_cnt_reg;

   // Outputs
   logic        wd_irq_req_reg;
   logic        sys_reset_req_reg;

   // Decode and mode signals
   logic            access;
   logic            wr_done;
   logic            hit_ctrl;
   logic            hit_cause;
   logic            wr_ctrl;
   logic            wr_cause;
   logic            fuse;
   logic            ie_eff;
   logic            wde_eff;
   logic            expire;
   logic            flag_set;
   logic            reset_fire;
   logic [7:0]      ctrl_read;
   logic [7:0]      cause_read;
   wd_pkg::wd_mode_e mode;

   wd_count_if cif ();

   // APB decode: one wait state, write lands on the pready edge
   assign access    = psel & penable;
   assign wr_done   = access & pready_reg & pwrite;
   assign hit_ctrl  = paddr[11:2] == wd_pkg::ADDR_CTRL_STATUS[11:2];
   assign hit_cause = paddr[11:2] == wd_pkg::ADDR_RESET_CAUSE[11:2];
   assign wr_ctrl   = wr_done & hit_ctrl;
   assign wr_cause  = wr_done & hit_cause;

   // Fuse is a pin, so it is synchronised before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_s1_reg <= 1'b0;
         fuse_s2_reg <= 1'b0;
      end else begin
         fuse_s1_reg <= wd_always_on_fuse;
         fuse_s2_reg <= fuse_s1_reg;
      end
   end

   assign fuse = fuse_s2_reg;

   assign ie_eff = ie_reg & ~fuse;
   assign wde_eff = wde_reg | cause_reg | fuse;

   always_comb begin
      unique case ({wde_eff, ie_eff})
         2'b00: mode = wd_pkg::MODE_STOPPED;
         2'b01: mode = wd_pkg::MODE_IRQ;
         2'b10: mode = wd_pkg::MODE_RESET;
         2'b11: mode = wd_pkg::MODE_IRQ_RESET;
      endcase
   end

   // Expiry action by mode
   always_comb begin
      flag_set   = 1'b0;
      reset_fire = 1'b0;
      unique case (mode)
         wd_pkg::MODE_STOPPED: begin
            flag_set   = 1'b0;
         end
         wd_pkg::MODE_IRQ: begin
            flag_set   = expire;
         end
         wd_pkg::MODE_RESET: begin
            reset_fire = expire;
         end
         wd_pkg::MODE_IRQ_RESET: begin
            flag_set   = expire & ~flag_reg;
            reset_fire = expire & flag_reg;
         end
      endcase
   end

   // Counter hookup
   assign cif.run     = mode != wd_pkg::MODE_STOPPED;
   assign cif.restart = wd_restart;
   assign cif.period  = period_reg;
   assign expire      = cif.expire;

   wd_counter #(
      .base_cycles (base_cycles),
      .cnt_w       (wd_pkg::WD_CNT_W)
   ) u_counter (
      .pclk       (pclk),
      .presetn    (presetn),
      .wd_osc_clk (wd_osc_clk),
      .cif        (cif)
   );

   // Time-out flag; a flag-setting expiry beats any clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_reg <= wd_pkg::RST_TIMEOUT_FLAG;
      end else begin
         if (flag_set) begin
            flag_reg <= 1'b1;
         end else if (wd_irq_enter) begin
            flag_reg <= 1'b0;
         end else if (wr_ctrl && pwdata[wd_pkg::BIT_TIMEOUT_FLAG]) begin
            flag_reg <= 1'b0;
         end
      end
   end

   // Interrupt enable, freely writable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ie_reg <= wd_pkg::RST_IRQ_ENABLE;
      end else begin
         if (wr_ctrl) begin
            ie_reg <= pwdata[wd_pkg::BIT_IRQ_ENABLE];
         end else if (wd_irq_enter && mode == wd_pkg::MODE_IRQ_RESET) begin
            ie_reg <= 1'b0;
         end
      end
   end

   // Unlock window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ce_reg     <= wd_pkg::RST_CHANGE_UNLCK;
         ce_cnt_reg <= '0;
      end else begin
         if (wr_ctrl && pwdata[wd_pkg::BIT_CHANGE_UNLCK]) begin
            ce_reg     <= 1'b1;
            ce_cnt_reg <= wd_pkg::UNLOCK_CNT_W'(wd_pkg::UNLOCK_CYCLES - 1);
         end else if (ce_cnt_reg != '0) begin
            ce_cnt_reg <= ce_cnt_reg - wd_pkg::UNLOCK_CNT_W'(1);
         end else begin
            ce_reg <= 1'b0;
         end
      end
   end

   // Reset enable and period; the window is judged on the value before the write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wde_reg    <= wd_pkg::RST_RESET_ENABLE;
         period_reg <= wd_pkg::RST_PERIOD;
      end else if (wr_ctrl) begin
         // Setting is always allowed; it only tightens the watchdog
         if (pwdata[wd_pkg::BIT_RESET_ENABLE]) begin
            wde_reg <= 1'b1;
         // clear only unlocked, never while forced
         end else if (ce_reg && !cause_reg && !fuse) begin
            wde_reg <= 1'b0;
         end
         if (ce_reg) begin
            period_reg <= {pwdata[wd_pkg::BIT_PERIOD3],
                           pwdata[wd_pkg::BIT_PERIOD_HI:wd_pkg::BIT_PERIOD_LO]};
         end
      end
   end

   // Reset cause; survives the system reset it reports
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_reg <= wd_pkg::RST_RESET_CAUSE;
      end else begin
         if (reset_fire) begin
            cause_reg <= 1'b1;
         end else if (wr_cause && !pwdata[wd_pkg::BIT_RESET_CAUSE]) begin
            cause_reg <= 1'b0;
         end
      end
   end

   // Outputs registered; request lags its inputs by one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_irq_req_reg    <= 1'b0;
         sys_reset_req_reg <= 1'b0;
      end else begin
         wd_irq_req_reg    <= global_irq_enable & ie_eff & flag_reg;
         sys_reset_req_reg <= reset_fire;
      end
   end

   // Read views
   assign ctrl_read = {flag_reg, ie_eff, period_reg[3], ce_reg, wde_eff, period_reg[2:0]};
   assign cause_read = 8'(cause_reg) << wd_pkg::BIT_RESET_CAUSE;

   // APB answer: unmapped addresses get pslverr and zero data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= access & ~pready_reg;
         pslverr_reg <= access & ~pready_reg & ~(hit_ctrl | hit_cause);
         if (access && !pready_reg && !pwrite && hit_ctrl) begin
            prdata_reg <= {24'h00_0000, ctrl_read};
         end else if (access && !pready_reg && !pwrite && hit_cause) begin
            prdata_reg <= {24'h00_0000, cause_read};
         end else begin
            prdata_reg <= 32'h0000_0000;
         end
      end
   end

   assign prdata        = prdata_reg;
   assign pready        = pready_reg;
   assign pslverr       = pslverr_reg;
   assign wd_irq_req    = wd_irq_req_reg;
   assign sys_reset_req = sys_reset_req_reg;

endmodule

// ==== common/wd_pkg.sv ====
// Shared constants and types of the watchdog timer control block
package wd_pkg;

   // Register byte offsets on the APB
   localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
   localparam logic [11:0] ADDR_RESET_CAUSE = 12'h004;
   localparam int unsigned ADDR_W           = 12;
   localparam int unsigned DATA_W           = 32;

   // Field positions in watchdog_control_status
   localparam int unsigned BIT_TIMEOUT_FLAG = 7;
   localparam int unsigned BIT_IRQ_ENABLE   = 6;
   localparam int unsigned BIT_PERIOD3      = 5;
   localparam int unsigned BIT_CHANGE_UNLCK = 4;
   localparam int unsigned BIT_RESET_ENABLE = 3;
   localparam int unsigned BIT_PERIOD_HI    = 2;
   localparam int unsigned BIT_PERIOD_LO    = 0;

   // Field position in reset_cause_register
   localparam int unsigned BIT_RESET_CAUSE  = 3;

   // Values after reset
   localparam logic       RST_TIMEOUT_FLAG = 1'b0;
   localparam logic       RST_IRQ_ENABLE   = 1'b0;
   localparam logic       RST_CHANGE_UNLCK = 1'b0;
   localparam logic       RST_RESET_ENABLE = 1'b0;
   localparam logic       RST_RESET_CAUSE  = 1'b0;
   localparam logic [3:0] RST_PERIOD       = 4'h0;

   // Cycle counts
   localparam int unsigned UNLOCK_CYCLES    = 4;
   localparam int unsigned UNLOCK_CNT_W     = 3;
   localparam int unsigned PERIOD_BASE      = 2048;
   localparam logic [3:0]  PERIOD_MAX_CODE  = 4'h9;
   localparam int unsigned WD_CNT_W         = 21;

   // Clock rates
   localparam int unsigned PCLK_HZ          = 40000000;
   localparam int unsigned WD_OSC_HZ        = 128000;

   typedef enum logic [1:0] {
      MODE_STOPPED,
      MODE_IRQ,
      MODE_RESET,
      MODE_IRQ_RESET
   } wd_mode_e;

endpackage

// ==== common/wd_count_if.sv ====
// Link between the watchdog control logic and its time-out counter
`timescale 1ns/1ps
interface wd_count_if;
   logic       run;
   logic       restart;
   logic [3:0] period;
   logic       expire;

   modport ctrl (
      output run,
      output restart,
      output period,
      input  expire
   );

   modport counter (
      input  run,
      input  restart,
      input  period,
      output expire
   );
endinterface

// ==== hw/wd_counter.sv ====
// Watchdog time-out counter driven by the synchronised oscillator pin
`timescale 1ns/1ps
module wd_counter #(
   parameter int unsigned base_cycles = wd_pkg::PERIOD_BASE,
   parameter int unsigned cnt_w       = wd_pkg::WD_CNT_W
) (
   input  wire logic  pclk,
   input  wire logic  presetn,
   input  wire logic  wd_osc_clk,
   wd_count_if.counter cif
);

   logic             osc_s1_reg;
   logic             osc_s2_reg;
   logic             osc_s3_reg;
   logic             tick;
   logic [3:0]       code;
   logic [cnt_w-1:0] limit;
   logic [cnt_w-1:0] cnt_reg;
   logic             expire_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_s1_reg <= 1'b0;
         osc_s2_reg <= 1'b0;
         osc_s3_reg <= 1'b0;
      end else begin
         osc_s1_reg <= wd_osc_clk;
         osc_s2_reg <= osc_s1_reg;
         osc_s3_reg <= osc_s2_reg;
      end
   end

   // One tick per oscillator rising edge, never two
   assign tick = osc_s2_reg & ~osc_s3_reg;

   assign code  = (cif.period > wd_pkg::PERIOD_MAX_CODE) ? wd_pkg::PERIOD_MAX_CODE : cif.period;
   assign limit = cnt_w'(base_cycles) << code;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg    <= '0;
         expire_reg <= 1'b0;
      end else begin
         expire_reg <= 1'b0;
         if (!cif.run || cif.restart) begin
            cnt_reg <= '0;
         end else if (tick) begin
            // Compare with >= so a shortened period expires at the next tick
            if (cnt_reg >= limit - cnt_w'(1)) begin
               cnt_reg    <= '0;
               expire_reg <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + cnt_w'(1);
            end
         end
      end
   end

   assign cif.expire = expire_reg;

endmodule

// ==== test/watchdog_timer_control_assertions.sv ====
// Port-level checks for the watchdog timer control block
`timescale 1ns/1ps
module watchdog_timer_control_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        wd_always_on_fuse,
   input wire logic        global_irq_enable,
   input wire logic        wd_irq_enter,
   input wire logic        wd_irq_req,
   input wire logic        sys_reset_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_first_access;
      psel && penable && !pready;
   endsequence
   // Fuse must be seen past its synchroniser
   sequence s_fuse_held;
      wd_always_on_fuse [*5];
   endsequence

   property p_one_wait; s_first_access |=> pready; endproperty
   property p_ready_pulse; pready |=> !pready; endproperty
   property p_unmapped; pready && paddr[11:2] > 10'h1 |-> pslverr && prdata == 32'h0; endproperty
   property p_upper_zero; !pready || prdata[31:8] == 24'h0; endproperty
   property p_irq_needs_gie; wd_irq_req |-> $past(global_irq_enable); endproperty
   property p_enter_clears; wd_irq_enter |=> ##1 !wd_irq_req; endproperty
   property p_reset_pulse; sys_reset_req |=> !sys_reset_req; endproperty
   property p_fuse_no_irq; s_fuse_held |-> !wd_irq_req; endproperty
   property p_fuse_read; s_fuse_held ##0 (pready && !pwrite && paddr[11:2] == 10'h0) |-> prdata[3] && !prdata[6];
   endproperty

   a_one_wait: assert property (p_one_wait) else $error("pready not after one wait");
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
   a_unmapped: assert property (p_unmapped) else $error("unmapped access");
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
   a_irq_needs_gie: assert property (p_irq_needs_gie) else $error("irq without global enable");
   a_enter_clears: assert property (p_enter_clears) else $error("irq after handler entry");
   a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long");
   a_fuse_no_irq: assert property (p_fuse_no_irq) else $error("irq with fuse set");
   a_fuse_read: assert property (p_fuse_read) else $error("fuse not forcing bits");
endmodule

bind watchdog_timer_control watchdog_timer_control_assertions u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .wd_always_on_fuse(wd_always_on_fuse),
   .global_irq_enable(global_irq_enable), .wd_irq_enter(wd_irq_enter), .wd_irq_req(wd_irq_req),
   .sys_reset_req(sys_reset_req)
);

// ==== test/watchdog_timer_control_tb_top.sv ====
// Self-checking testbench of the watchdog timer control block
`timescale 1ns/1ps
module watchdog_timer_control_tb_top;
   localparam int unsigned base = 4;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic        pready, pslverr, wd_irq_req, sys_reset_req;
   logic        wd_osc_clk = 0, fuse = 0, gie = 0, wd_irq_enter = 0, wd_restart = 1;
   logic [32:0] exp_q[$];
   int          num_errors = 0, compares = 0, rst_cnt = 0, seed;

   watchdog_timer_control #(.base_cycles(base)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wd_osc_clk(wd_osc_clk),
      .wd_always_on_fuse(fuse), .global_irq_enable(gie), .wd_irq_enter(wd_irq_enter),
      .wd_restart(wd_restart), .wd_irq_req(wd_irq_req), .sys_reset_req(sys_reset_req));

   always #12.5 pclk = ~pclk;
   // Slow oscillator, eight bus cycles a tick
   always #100 wd_osc_clk = ~wd_osc_clk;

   task automatic fail(input string msg);
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask
   task automatic chk_bit(input logic got, input logic e, input string msg);
      compares++;
      if (got !== e) fail(msg);
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      // Upper data bits are random: they must be ignored
      pwdata <= {24'($random(seed)), d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail("bus timeout");
         final_report();
      end else begin
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic err, input logic [7:0] e);
      exp_q.push_back({err, 24'h0, e});
      apb(a, 1'b0, 8'h0);
   endtask
   task automatic wait_hi(input logic rst, input int lim, output int n);
      n = 0;
      do begin @(negedge pclk); n++; end while ((rst ? sys_reset_req : wd_irq_req) !== 1'b1 && n < lim);
      if ((rst ? sys_reset_req : wd_irq_req) !== 1'b1) begin
         fail("event missing");
         final_report();
      end else begin
         // Back on a rising edge so later stimulus stays edge-aligned
         @(posedge pclk);
      end
   endtask
   task automatic enter_handler();
      @(posedge pclk);
      wd_irq_enter <= 1'b1;
      @(posedge pclk);
      wd_irq_enter <= 1'b0;
   endtask
   task automatic final_report();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Read results checked mid-cycle, after the edge has settled
   always @(negedge pclk) begin
      if (sys_reset_req === 1'b1) rst_cnt++;
      if (psel && penable && pready && !pwrite) begin
         compares++;
         if (exp_q.size() == 0) fail("unexpected read");
         else if ({pslverr, prdata} !== exp_q.pop_front()) fail("read data");
      end
   end

   initial begin
      repeat (100000) @(posedge pclk);
      fail("global timeout");
      final_report();
   end

   initial begin
      int n, t;
      logic [3:0] p;
      seed = 44687;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h000, 1'b0, 8'h00);
      rd(12'h004, 1'b0, 8'h00);
      wr(12'h008, 8'hff);
      rd(12'h008, 1'b1, 8'h00);
      wr(12'h000, 8'h40);
      wd_restart <= 1'b0;
      repeat (50) @(posedge pclk);
      wd_restart <= 1'b1;
      rd(12'h000, 1'b0, 8'hc0);
      chk_bit(wd_irq_req, 1'b0, "irq while masked");
      gie <= 1'b1;
      wait_hi(1'b0, 5, n);
      wr(12'h000, 8'h40);
      rd(12'h000, 1'b0, 8'hc0);
      wr(12'h000, 8'hc0);
      rd(12'h000, 1'b0, 8'h40);
      wd_restart <= 1'b0;
      wait_hi(1'b0, 80, n);
      wd_restart <= 1'b1;
      enter_handler();
      rd(12'h000, 1'b0, 8'h40);
      chk_bit(rst_cnt == 0, 1'b1, "reset in irq mode");
      for (int c = 0; c < 10; c++) begin
         p = 4'(c);
         t = (base << c) * 8;
         wr(12'h000, 8'h18);
         // Counter held in restart while the period changes
         wr(12'h000, {2'b11, p[3], 2'b00, p[2:0]});
         rd(12'h000, 1'b0, {2'b01, p[3], 2'b00, p[2:0]});
         wd_restart <= 1'b0;
         wait_hi(1'b0, t + 40, n);
         wd_restart <= 1'b1;
         chk_bit(n >= t - 8 && n <= t + 24, 1'b1, "period length");
      end
      wr(12'h000, 8'hc0);
      rd(12'h000, 1'b0, 8'h61);
      wr(12'h000, 8'h58);
      rd(12'h000, 1'b0, 8'h79);
      wr(12'h000, 8'h40);
      rd(12'h000, 1'b0, 8'h69);
      wr(12'h000, 8'h58);
      wr(12'h000, 8'h48);
      wd_restart <= 1'b0;
      wait_hi(1'b0, 80, n);
      wd_restart <= 1'b1;
      chk_bit(rst_cnt == 0, 1'b1, "early reset");
      enter_handler();
      rd(12'h000, 1'b0, 8'h08);
      // Re-arm outside the handler
      wr(12'h000, 8'h48);
      wd_restart <= 1'b0;
      wait_hi(1'b0, 80, n);
      wait_hi(1'b1, 80, n);
      wd_restart <= 1'b1;
      rd(12'h004, 1'b0, 8'h08);
      wr(12'h000, 8'h18);
      wr(12'h000, 8'h00);
      rd(12'h000, 1'b0, 8'h88);
      wr(12'h004, 8'h00);
      rd(12'h004, 1'b0, 8'h00);
      // Clear attempted while forced must not have taken
      rd(12'h000, 1'b0, 8'h88);
      wr(12'h000, 8'h98);
      wr(12'h000, 8'h00);
      rd(12'h000, 1'b0, 8'h00);
      wd_restart <= 1'b0;
      repeat (80) @(posedge pclk);
      chk_bit(rst_cnt == 1 && wd_irq_req === 1'b0, 1'b1, "stopped counter fired");
      fuse <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(12'h000, 1'b0, 8'h08);
      wait_hi(1'b1, 80, n);
      rd(12'h004, 1'b0, 8'h08);
      final_report();
   end
endmodule
